//--- verilog/sdram_pin_pkg.sv
package sdram_pin_pkg;

    localparam int unsigned BANK_W     = 2;
    localparam int unsigned BANKS      = 4;
    localparam int unsigned ADDR_W     = 11;
    localparam int unsigned COL_W      = 8;
    localparam int unsigned DQ_W       = 32;
    localparam int unsigned BYTES      = 4;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned AP_BIT     = 10;
    // Storage kept per bank: a small window of columns
    localparam int unsigned COL_IDX_W  = 2;
    localparam int unsigned WORD_IDX_W = BANK_W + COL_IDX_W;
    localparam int unsigned WORDS      = 1 << WORD_IDX_W;
    // Edges from a registered byte mask to the read data it governs
    localparam int unsigned MASK_LAT   = 2;
    // Edges from the controller driving a read to it sampling the data
    localparam int unsigned CTRL_RD_LAT = MASK_LAT + 2;
    // Idle edges required after leaving self refresh
    localparam int unsigned SREF_EXIT_NOPS = 2;
    localparam int unsigned EXIT_CNT_W  = 2;
    localparam int unsigned REF_CNT_W   = 16;

    localparam logic [ADDR_W-1:0]     MODE_RST     = 11'h000;
    localparam logic [ADDR_W-1:0]     ROW_RST      = 11'h000;
    localparam logic [REF_CNT_W-1:0]  REF_CNT_RST  = 16'h0000;
    localparam logic [EXIT_CNT_W-1:0] EXIT_CNT_MAX = 2'h2;
    localparam logic [DQ_W-1:0]       DQ_RST       = 32'h0000_0000;

    // Encoding is {row strobe, column strobe, write enable}, all active low
    typedef enum logic [2:0] {
        CMD_LMR = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR  = 3'h4,
        CMD_RD  = 3'h5,
        CMD_BST = 3'h6,
        CMD_NOP = 3'h7
    } cmd_e;

    typedef enum logic [1:0] {
        PS_ACTIVE        = 2'h0,
        PS_POWER_DOWN    = 2'h1,
        PS_CLOCK_SUSPEND = 2'h3,
        PS_SELF_REFRESH  = 2'h2
    } pwr_state_e;

    function automatic cmd_e decode_cmd(input logic cs_n,
                                        input logic ras_n,
                                        input logic cas_n,
                                        input logic we_n);
        return cs_n ? CMD_NOP : cmd_e'({ras_n, cas_n, we_n});
    endfunction

    function automatic logic [WORD_IDX_W-1:0] word_index(input logic [BANK_W-1:0] bank,
                                                         input logic [ADDR_W-1:0] addr);
        return {bank, addr[COL_IDX_W-1:0]};
    endfunction

endpackage

//--- verilog/sdram_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sdram_pin_if;
    import sdram_pin_pkg::*;

    logic                 cke;
    logic                 cs_n;
    logic                 ras_n;
    logic                 cas_n;
    logic                 we_n;
    logic [BANK_W-1:0]    ba;
    logic [ADDR_W-1:0]    addr;
    logic [BYTES-1:0]     dqm;
    logic [DQ_W-1:0]      ctl_dq;
    logic                 ctl_dq_oe;
    logic [DQ_W-1:0]      mem_dq;
    logic [BYTES-1:0]     mem_dq_oe;
    logic [DQ_W-1:0]      dq;

    // Shared data wire: memory lanes win, then controller, undriven reads zero
    genvar b;
    for (b = 0; b < BYTES; b++) begin : g_lane
        assign dq[b*BYTE_W +: BYTE_W] = mem_dq_oe[b] ? mem_dq[b*BYTE_W +: BYTE_W] :
                                        ctl_dq_oe    ? ctl_dq[b*BYTE_W +: BYTE_W] :
                                                       8'h00;
    end

    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe,
        input  dq
    );

    modport mem (
        input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
        output mem_dq, mem_dq_oe
    );

endinterface
`default_nettype wire

//--- verilog/sdram_device_end.sv
// Contract
// - Edge counts only while clock enable high
// - Clock enable low: power-down, suspend or self refresh
// - Clock enable level acts without a sampling delay
// - Other inputs captured on rising clock edge
// - Chip select high ignores commands, holds state
// - Each byte mask governs its own eight lines
// - Read: mask low drives byte, high floats it
// - Write: mask low stores byte, high discards it
// - Activate takes row from eleven address lines
// - Read/write: column lines 0-7, line 10 autoprecharge; storage here decodes column lines 0-1 only
// - Precharge: line 10 high all, low one bank
// - Load mode takes op-code from address lines
// - Bank inputs pick bank for four commands
// - Command decoded from strobes with chip select low
// - Read mask takes effect two clocks later
// - Refresh: auto if enable high, self if low
`timescale 1ns/100ps
`default_nettype none
module sdram_device_end (
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    sdram_pin_if.mem                               pin_io,
    output var  sdram_pin_pkg::pwr_state_e         pwr_state_o,
    output var  logic [sdram_pin_pkg::ADDR_W-1:0]  mode_o,
    output var  logic [sdram_pin_pkg::BANKS-1:0]   bank_open_o,
    output var  logic [sdram_pin_pkg::REF_CNT_W-1:0] ref_cnt_o
);
    import sdram_pin_pkg::*;

    pwr_state_e              pwr_state_r;
    logic [ADDR_W-1:0]       mode_r;
    logic [BANKS-1:0]        bank_open_r;
    // Open row of each bank; storage itself is indexed by bank and column only
    logic [ADDR_W-1:0]       row_r [BANKS];
    logic [REF_CNT_W-1:0]    ref_cnt_r;
    logic [EXIT_CNT_W-1:0]   exit_cnt_r;
    logic [MASK_LAT-1:0]     rd_pend_r;
    logic [BYTES-1:0]        dqm_pipe_r [MASK_LAT];
    logic [DQ_W-1:0]         rd_data_r  [MASK_LAT];
    logic [DQ_W-1:0]         dq_out_r;
    logic [BYTES-1:0]        dq_oe_r;

    logic                    edge_ok;
    logic                    cmd_ok;
    cmd_e                    cmd;
    logic [WORD_IDX_W-1:0]   idx;
    logic [DQ_W-1:0]         rd_word;
    logic                    wr_go;
    logic                    rd_go;

    // The enable level acts on the edge it stands at, with no register in between
    assign edge_ok = pin_io.cke;
    assign cmd     = decode_cmd(pin_io.cs_n, pin_io.ras_n,
                                pin_io.cas_n, pin_io.we_n);
    // Commands only count on a live edge, awake, and past self refresh exit
    assign cmd_ok  = edge_ok && (pwr_state_r == PS_ACTIVE) &&
                     (exit_cnt_r == '0);
    assign idx     = word_index(pin_io.ba, pin_io.addr);
    // Accepted accesses for the storage and the read pipe
    assign wr_go   = cmd_ok && (cmd == CMD_WR);
    assign rd_go   = cmd_ok && (cmd == CMD_RD);

    // Power state follows the enable level of the current edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pwr_state_r <= PS_ACTIVE;
        end else begin
            case (pwr_state_r)
                PS_ACTIVE: begin
                    // On a dead edge a refresh means self refresh; otherwise a read in flight means clock suspend
                    if (!edge_ok) begin
                        if (cmd == CMD_REF) begin
                            pwr_state_r <= PS_SELF_REFRESH;
                        end else if (|rd_pend_r || dq_oe_r != '0) begin
                            pwr_state_r <= PS_CLOCK_SUSPEND;
                        end else begin
                            pwr_state_r <= PS_POWER_DOWN;
                        end
                    end
                end
                PS_POWER_DOWN, PS_CLOCK_SUSPEND, PS_SELF_REFRESH: begin
                    if (edge_ok) begin
                        pwr_state_r <= PS_ACTIVE;
                    end
                end
                default: pwr_state_r <= PS_ACTIVE;
            endcase
        end
    end

    // After self refresh the first edges must stay idle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            exit_cnt_r <= '0;
        end else if (pwr_state_r == PS_SELF_REFRESH && edge_ok) begin
            exit_cnt_r <= EXIT_CNT_MAX;
        end else if (exit_cnt_r != '0 && edge_ok) begin
            exit_cnt_r <= exit_cnt_r - 1'b1;
        end
    end

    // Op-code is held whole; its fields are not interpreted here
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode_r <= MODE_RST;
        end else if (cmd_ok && cmd == CMD_LMR) begin
            mode_r <= pin_io.addr;
        end
    end

    // Rows open on activate, close on precharge or auto precharge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bank_open_r <= '0;
            for (int i = 0; i < BANKS; i++) begin
                row_r[i] <= ROW_RST;
            end
        end else if (cmd_ok) begin
            case (cmd)
                CMD_ACT: begin
                    bank_open_r[pin_io.ba] <= 1'b1;
                    row_r[pin_io.ba]       <= pin_io.addr;
                end
                CMD_PRE: begin
                    if (pin_io.addr[AP_BIT]) begin
                        bank_open_r <= '0;
                    end else begin
                        bank_open_r[pin_io.ba] <= 1'b0;
                    end
                end
                CMD_RD, CMD_WR: begin
                    if (pin_io.addr[AP_BIT]) begin
                        bank_open_r[pin_io.ba] <= 1'b0;
                    end
                end
                default: bank_open_r <= bank_open_r;
            endcase
        end
    end

    // Auto refreshes only; a refresh on a dead edge enters self refresh instead
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ref_cnt_r <= REF_CNT_RST;
        end else if (cmd_ok && cmd == CMD_REF) begin
            ref_cnt_r <= ref_cnt_r + 1'b1;
        end
    end

    // Storage, one lane per byte so each mask gates only its own lines
    genvar b;
    for (b = 0; b < BYTES; b++) begin : g_lane
        logic [BYTE_W-1:0] lane_r [WORDS];
        always_ff @(posedge clk_i) begin
            if (wr_go && !pin_io.dqm[b]) begin
                lane_r[idx] <= pin_io.dq[b*BYTE_W +: BYTE_W];
            end
        end
        assign rd_word[b*BYTE_W +: BYTE_W] = lane_r[idx];
    end

    // Read pipe; a dead edge freezes it, burst stop drops only the read accepted one edge before it
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_pend_r <= '0;
            for (int i = 0; i < MASK_LAT; i++) begin
                rd_data_r[i]  <= DQ_RST;
                dqm_pipe_r[i] <= '0;
            end
        end else if (edge_ok) begin
            rd_pend_r[0]  <= rd_go;
            rd_data_r[0]  <= rd_word;
            dqm_pipe_r[0] <= pin_io.dqm;
            for (int i = 1; i < MASK_LAT; i++) begin
                rd_pend_r[i]  <= rd_pend_r[i-1] &&
                                 !(cmd_ok && cmd == CMD_BST);
                rd_data_r[i]  <= rd_data_r[i-1];
                dqm_pipe_r[i] <= dqm_pipe_r[i-1];
            end
        end
    end

    // Lanes drive one edge after the pipe ends, each gated by its own mask
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dq_out_r <= DQ_RST;
            dq_oe_r  <= '0;
        end else if (edge_ok) begin
            dq_out_r <= rd_data_r[MASK_LAT-1];
            for (int i = 0; i < BYTES; i++) begin
                dq_oe_r[i] <= rd_pend_r[MASK_LAT-1] &&
                              !dqm_pipe_r[MASK_LAT-1][i];
            end
        end
    end

    // Every output is a plain copy of a flop
    assign pin_io.mem_dq    = dq_out_r;
    assign pin_io.mem_dq_oe = dq_oe_r;
    assign pwr_state_o      = pwr_state_r;
    assign mode_o           = mode_r;
    assign bank_open_o      = bank_open_r;
    assign ref_cnt_o        = ref_cnt_r;

endmodule
`default_nettype wire

//--- verilog/sdram_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_end (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_b_i,
    sdram_pin_if.ctrl                                 pin_io,
    input  wire logic                                 cke_i,
    input  wire logic                                 cmd_valid_i,
    input  wire sdram_pin_pkg::cmd_e                  cmd_i,
    input  wire logic [sdram_pin_pkg::BANK_W-1:0]     bank_i,
    input  wire logic [sdram_pin_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [sdram_pin_pkg::DQ_W-1:0]       wdata_i,
    input  wire logic [sdram_pin_pkg::BYTES-1:0]      mask_i,
    output var  logic                                 cmd_ready_o,
    output var  logic [sdram_pin_pkg::DQ_W-1:0]       rdata_o,
    output var  logic                                 rvalid_o
);
    import sdram_pin_pkg::*;

    logic                    cke_r;
    logic                    cs_n_r;
    logic [2:0]              strobe_r;
    logic [BANK_W-1:0]       ba_r;
    logic [ADDR_W-1:0]       addr_r;
    logic [BYTES-1:0]        dqm_r;
    logic [DQ_W-1:0]         wdata_r;
    logic                    wdata_oe_r;
    logic                    ready_r;
    logic [CTRL_RD_LAT-1:0]  rd_sh_r;
    logic [DQ_W-1:0]         rdata_r;
    logic                    rvalid_r;
    logic                    take;

    // A refresh with the enable low is the self refresh entry
    assign take = cmd_valid_i && ready_r && cmd_i != CMD_NOP &&
                  (cke_i || cmd_i == CMD_REF);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ready_r <= 1'b0;
            cke_r   <= 1'b1;
        end else begin
            ready_r <= 1'b1;
            cke_r   <= cke_i;
        end
    end

    // Pins launched from flops so the device samples them on the next edge
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cs_n_r   <= 1'b1;
            strobe_r <= CMD_NOP;
            ba_r     <= '0;
            addr_r   <= '0;
            dqm_r    <= '0;
        end else begin
            cs_n_r   <= !take;
            strobe_r <= take ? cmd_i : CMD_NOP;
            ba_r     <= bank_i;
            addr_r   <= addr_i;
            dqm_r    <= mask_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wdata_r    <= DQ_RST;
            wdata_oe_r <= 1'b0;
        end else begin
            wdata_r    <= wdata_i;
            wdata_oe_r <= take && cmd_i == CMD_WR;
        end
    end

    // Read data comes back a fixed number of edges after launch
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_sh_r  <= '0;
            rdata_r  <= DQ_RST;
            rvalid_r <= 1'b0;
        end else begin
            rd_sh_r  <= {rd_sh_r[CTRL_RD_LAT-2:0], take && cmd_i == CMD_RD};
            rvalid_r <= rd_sh_r[CTRL_RD_LAT-1];
            if (rd_sh_r[CTRL_RD_LAT-1]) begin
                rdata_r <= pin_io.dq;
            end
        end
    end

    assign pin_io.cke       = cke_r;
    assign pin_io.cs_n      = cs_n_r;
    assign pin_io.ras_n     = strobe_r[2];
    assign pin_io.cas_n     = strobe_r[1];
    assign pin_io.we_n      = strobe_r[0];
    assign pin_io.ba        = ba_r;
    assign pin_io.addr      = addr_r;
    assign pin_io.dqm       = dqm_r;
    assign pin_io.ctl_dq    = wdata_r;
    assign pin_io.ctl_dq_oe = wdata_oe_r;
    assign cmd_ready_o      = ready_r;
    assign rdata_o          = rdata_r;
    assign rvalid_o         = rvalid_r;

endmodule
`default_nettype wire

//--- verif/sdram_pin_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_assertions
    import sdram_pin_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             cke,
    input  wire logic             cs_n,
    input  wire logic             ras_n,
    input  wire logic             cas_n,
    input  wire logic             we_n,
    input  wire logic [BYTES-1:0] dqm,
    input  wire logic             ctl_dq_oe,
    input  wire logic [BYTES-1:0] mem_dq_oe
);
    wire logic [2:0] cmd = {ras_n, cas_n, we_n};
    wire logic       rd  = !cs_n && cmd == CMD_RD;
    wire logic       wr  = !cs_n && cmd == CMD_WR;
    wire logic       bst = !cs_n && cmd == CMD_BST;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // Read sampled with the clock enabled long enough to clear any exit window
    sequence s_rd_ok;
        cke [*5] ##0 rd;
    endsequence

    sequence s_rd_flow;
        s_rd_ok ##1 (cke && !bst) ##1 cke;
    endsequence

    AST_RD_MASK: assert property (s_rd_flow |=> mem_dq_oe == ~$past(dqm, 3))
        else $error("read lanes do not follow the mask");
    AST_BST_KILL: assert property (s_rd_ok ##1 (cke && bst) ##1 cke |=> mem_dq_oe == '0)
        else $error("stopped read still drives");
    AST_OE_CAUSE: assert property (|mem_dq_oe && $past(cke) && $past(cke, 2) &&
        $past(cke, 3) |-> $past(rd, 3))
        else $error("lanes driven without a read");
    AST_RST_IDLE: assert property ($rose(rst_b_i) |-> cs_n && cke && !ctl_dq_oe &&
        mem_dq_oe == '0)
        else $error("pins not idle after reset");
    AST_WR_DRIVES: assert property (wr |-> ctl_dq_oe)
        else $error("write without data drive");
    AST_DRIVE_ONLY_WR: assert property (ctl_dq_oe |-> wr)
        else $error("data driven outside a write");
    AST_CKE_LOW_CMD: assert property (!cke |-> cs_n || cmd == CMD_REF)
        else $error("command other than refresh with clock disabled");
    AST_CS_QUIET: assert property ((cs_n && cke) [*4] |-> mem_dq_oe == '0)
        else $error("lanes driven while deselected");
endmodule
`default_nettype wire

//--- verif/sdram_pin_command_interface_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, g) \
    begin \
        samples_checked++; \
        if ((g) !== (x)) begin \
            bad_count++; \
            $display("Error %s expected %0h seen %0h", n, x, g); \
        end \
    end
module sdram_pin_command_interface_tb;
    import sdram_pin_pkg::*;
    logic                 clk_i;
    logic                 rst_b_i;
    logic                 cke_i;
    logic                 cmd_valid_i;
    logic                 cmd_ready_o;
    logic                 rvalid_o;
    cmd_e                 cmd_i;
    logic [BANK_W-1:0]    bank_i;
    logic [ADDR_W-1:0]    addr_i;
    logic [DQ_W-1:0]      wdata_i;
    logic [DQ_W-1:0]      rdata_o;
    logic [BYTES-1:0]     mask_i;
    pwr_state_e           pwr_state_o;
    logic [ADDR_W-1:0]    mode_o;
    logic [BANKS-1:0]     bank_open_o;
    logic [REF_CNT_W-1:0] ref_cnt_o;
    int                   bad_count;
    int                   samples_checked;
    int                   seed;
    bit                   ignore_rd;
    logic [DQ_W-1:0]      v;
    logic [DQ_W-1:0]      exp_v;
    logic [DQ_W-1:0]      exp_mem [WORDS];
    logic [DQ_W-1:0]      exp_q [$];
    logic [BANKS-1:0]     open_exp;
    logic [REF_CNT_W-1:0] ref_exp;

    sdram_pin_if pin_if ();
    sdram_device_end sdram_device_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_io(pin_if),
        .pwr_state_o(pwr_state_o), .mode_o(mode_o), .bank_open_o(bank_open_o),
        .ref_cnt_o(ref_cnt_o));
    sdram_ctrl_end sdram_ctrl_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_io(pin_if),
        .cke_i(cke_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .bank_i(bank_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .mask_i(mask_i), .cmd_ready_o(cmd_ready_o),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o));
    sdram_pin_assertions sdram_pin_assertions_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cke(pin_if.cke), .cs_n(pin_if.cs_n), .ras_n(pin_if.ras_n), .cas_n(pin_if.cas_n),
        .we_n(pin_if.we_n), .dqm(pin_if.dqm), .ctl_dq_oe(pin_if.ctl_dq_oe),
        .mem_dq_oe(pin_if.mem_dq_oe));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Issues one request and tracks what the memory should then hold
    task automatic op(input cmd_e c, input logic [1:0] b, input logic [10:0] a,
                      input logic [31:0] d, input logic [3:0] m, input logic k);
        int wd;
        logic [31:0] e;
        logic [3:0] idx;
        wd = 0;
        idx = {b, a[1:0]};
        #1;
        cke_i = k;
        cmd_valid_i = 1'b1;
        cmd_i = c;
        bank_i = b;
        addr_i = a;
        wdata_i = d;
        mask_i = m;
        while (cmd_ready_o !== 1'b1 && wd < 20) begin
            @(posedge clk_i);
            #1;
            wd++;
        end
        @(posedge clk_i);
        if (k) begin
            for (int j = 0; j < BYTES; j++) begin
                if (c == CMD_WR && !m[j]) exp_mem[idx][j*8 +: 8] = d[j*8 +: 8];
            end
            e = exp_mem[idx];
            for (int j = 0; j < BYTES; j++) begin
                if (m[j]) e[j*8 +: 8] = 8'h00;
            end
            if (c == CMD_RD && !ignore_rd) exp_q.push_back(e);
            if (c == CMD_ACT) open_exp[b] = 1'b1;
            if ((c == CMD_RD || c == CMD_WR || c == CMD_PRE) && !a[10]) begin
                if (c == CMD_PRE) open_exp[b] = 1'b0;
            end else if (c == CMD_PRE) begin
                open_exp = '0;
            end else if (c == CMD_RD || c == CMD_WR) begin
                open_exp[b] = 1'b0;
            end
            if (c == CMD_REF) ref_exp++;
        end
    endtask

    task automatic idle(input int n, input logic k);
        #1;
        cmd_valid_i = 1'b0;
        cke_i = k;
        repeat (n) @(posedge clk_i);
    endtask

    always @(negedge clk_i) begin
        if (rvalid_o === 1'b1 && !ignore_rd) begin
            if (exp_q.size() == 0) begin
                `CHK("read surplus", 1'b0, 1'b1)
            end else begin
                exp_v = exp_q.pop_front();
                `CHK("read data", exp_v, rdata_o)
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        stop_test();
    end

    initial begin
        seed = 32'hA68F;
        bad_count = 0;
        samples_checked = 0;
        ignore_rd = 1'b0;
        open_exp = '0;
        ref_exp = '0;
        rst_b_i = 1'b0;
        cke_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_i = CMD_NOP;
        bank_i = '0;
        addr_i = '0;
        wdata_i = '0;
        mask_i = '0;
        repeat (16) @(posedge clk_i);
        `CHK("ready", 1'b0, cmd_ready_o)
        #1 rst_b_i = 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("ready", 1'b1, cmd_ready_o)
        `CHK("power", PS_ACTIVE, pwr_state_o)
        `CHK("refreshes", REF_CNT_RST, ref_cnt_o)
        v = $random(seed);
        op(CMD_LMR, 2'h0, v[10:0], 32'h0, 4'h0, 1'b1);
        idle(2, 1'b1);
        `CHK("mode", v[10:0], mode_o)
        for (int i = 0; i < BANKS; i++) op(CMD_ACT, 2'(i), 11'($random(seed)), 32'h0, 4'h0, 1'b1);
        for (int i = 0; i < WORDS; i++) op(CMD_WR, 2'(i >> 2), 11'(i & 3), $random(seed), 4'h0, 1'b1);
        idle(2, 1'b1);
        `CHK("open banks", open_exp, bank_open_o)
        // Write with a random mask, then two reads back to back
        repeat (24) begin
            v = $random(seed);
            op(CMD_WR, v[5:4], {1'b0, v[15:8], v[1:0]}, $random(seed), v[19:16], 1'b1);
            op(CMD_RD, v[5:4], {1'b0, v[15:8], v[1:0]}, 32'h0, v[23:20], 1'b1);
            op(CMD_RD, v[7:6], {9'h0, v[3:2]}, 32'h0, v[27:24], 1'b1);
            idle(6, 1'b1);
        end
        op(CMD_RD, 2'h1, 11'h400, 32'h0, 4'h0, 1'b1);
        idle(6, 1'b1);
        `CHK("auto close", open_exp, bank_open_o)
        op(CMD_PRE, 2'h2, 11'h000, 32'h0, 4'h0, 1'b1);
        idle(2, 1'b1);
        `CHK("one closed", open_exp, bank_open_o)
        op(CMD_PRE, 2'h0, 11'h400, 32'h0, 4'h0, 1'b1);
        idle(2, 1'b1);
        `CHK("all closed", open_exp, bank_open_o)
        repeat (3) op(CMD_REF, 2'h0, 11'h0, 32'h0, 4'h0, 1'b1);
        idle(2, 1'b1);
        `CHK("refreshes", ref_exp, ref_cnt_o)
        // Clock disabled: an activate is refused
        op(CMD_ACT, 2'h3, 11'h0, 32'h0, 4'h0, 1'b0);
        idle(3, 1'b0);
        `CHK("power", PS_POWER_DOWN, pwr_state_o)
        `CHK("refused", open_exp, bank_open_o)
        idle(4, 1'b1);
        `CHK("power", PS_ACTIVE, pwr_state_o)
        op(CMD_REF, 2'h0, 11'h0, 32'h0, 4'h0, 1'b0);
        idle(3, 1'b0);
        `CHK("power", PS_SELF_REFRESH, pwr_state_o)
        `CHK("refreshes", ref_exp, ref_cnt_o)
        idle(6, 1'b1);
        `CHK("power", PS_ACTIVE, pwr_state_o)
        // A burst stop right behind a read leaves the lanes undriven: zero returns
        op(CMD_ACT, 2'h0, 11'h0, 32'h0, 4'h0, 1'b1);
        ignore_rd = 1'b1;
        op(CMD_RD, 2'h0, 11'h0, 32'h0, 4'h0, 1'b1);
        ignore_rd = 1'b0;
        exp_q.push_back(DQ_RST);
        op(CMD_BST, 2'h0, 11'h0, 32'h0, 4'h0, 1'b1);
        idle(8, 1'b1);
        // A dead edge behind a read holds it in the pipe; the early return is not valid
        ignore_rd = 1'b1;
        op(CMD_RD, 2'h0, 11'h0, 32'h0, 4'h0, 1'b1);
        idle(3, 1'b0);
        `CHK("power", PS_CLOCK_SUSPEND, pwr_state_o)
        idle(6, 1'b1);
        ignore_rd = 1'b0;
        `CHK("power", PS_ACTIVE, pwr_state_o)
        `CHK("pending reads", 0, exp_q.size())
        stop_test();
    end
endmodule
`default_nettype wire
